// >>> core/shb_pkg.sv
/*
 * Shared constants, types and the address decoder for the shared bus fabric.
 * Assumes a 32-bit byte-addressed shared bus with three masters.
 */
`default_nettype none

package shb_pkg;

    // Master indices; a lower index wins a tie between equal keys.
    localparam int unsigned NUM_M = 3;
    localparam int unsigned M_CPU = 0;
    localparam int unsigned M_PCIE = 1;
    localparam int unsigned M_REGB = 2;

    // Priority and token widths.
    localparam int unsigned LEVEL_W = 4;
    localparam logic [3:0] LEVEL_MAX = 4'hf;
    localparam int unsigned TOK_W = 16;

    // Transfer size code for a full 32-bit word.
    localparam logic [1:0] SZ_WORD = 2'h2;

    // Region boundaries of the physical map.
    localparam logic [31:0] BASE_LOW_RSVD = 32'h1000_0000;
    localparam logic [31:0] BASE_DDR_512 = 32'h2000_0000;
    localparam logic [31:0] BASE_FLASH = 32'h4000_0000;
    localparam logic [31:0] BASE_MID_RSVD = 32'h5000_0000;
    localparam logic [31:0] BASE_CHIP = 32'h7000_0000;
    localparam logic [31:0] BASE_SWC = 32'h7100_0000;
    localparam logic [31:0] END_SWC = 32'h7200_0000;
    localparam logic [31:0] BASE_HIGH = 32'h8000_0000;
    localparam logic [31:0] BASE_PCIE = 32'hc000_0000;

    // Target offset widths.
    localparam int unsigned FLASH_OFS_W = 28;
    localparam int unsigned DDR_OFS_W = 30;
    localparam int unsigned CHIP_OFS_W = 28;

    // Decoded target of one beat.
    typedef enum logic [2:0] {
        RG_RSVD = 3'h0,
        RG_FLASH_MIR = 3'h1,
        RG_DDR_MIR = 3'h2,
        RG_DDR = 3'h3,
        RG_FLASH = 3'h4,
        RG_CHIP = 3'h5,
        RG_PCIE = 3'h6
    } shb_region_t;

    // Register window sequencing.
    typedef enum logic [1:0] {
        RW_IDLE = 2'h0,
        RW_WRITE = 2'h1,
        RW_READ = 2'h2,
        RW_RDATA = 2'h3
    } shb_rw_state_t;

    // Maps an address to its region under the current boot and memory layout.
    function automatic shb_region_t decode_region(input logic [31:0] a, input logic boot,
                                                  input logic big);
        shb_region_t r;
        r = RG_RSVD;
        if (a >= BASE_PCIE) r = RG_PCIE;
        else if (a >= BASE_HIGH) r = big ? RG_DDR : RG_RSVD;
        else if (a >= BASE_CHIP) r = RG_CHIP;
        else if (a >= BASE_MID_RSVD) r = RG_RSVD;
        else if (a >= BASE_FLASH) r = RG_FLASH;
        else if (a >= BASE_DDR_512 && !big) r = RG_DDR;
        else if (boot) r = (a < BASE_LOW_RSVD) ? RG_FLASH_MIR : RG_RSVD;
        else r = RG_DDR_MIR;
        return r;
    endfunction

endpackage

`default_nettype wire

// >>> core/shb_prio_pick.sv
/*
 * Picks one requesting master by key; the key is the token bit above the level.
 * Assumes keys are stable in the cycle the pick is used.
 */
`default_nettype none

module shb_prio_pick (
    // Clock and reset, used by the checks only.
    input wire logic core_clk,
    input wire logic sys_rst,
    // Requests and their keys.
    input wire logic [2:0] req,
    input wire logic [2:0][4:0] key,
    // One-hot choice.
    output logic [2:0] pick
);

    // A strict greater-than keeps the lowest index on a tie, so the CPU wins by default.
    always_comb begin
        logic found;
        logic [4:0] best;
        found = 1'b0;
        best = 5'h00;
        pick = 3'h0;
        for (int i = 0; i < 3; i++) begin
            if (req[i] && (!found || key[i] > best)) begin
                found = 1'b1;
                best = key[i];
                pick = 3'h0;
                pick[i] = 1'b1;
            end
        end
    end

    wire logic tok_any = |(req & {key[2][4], key[1][4], key[0][4]});
    wire logic tok_won = |(pick & {key[2][4], key[1][4], key[0][4]});

    property p_token_first;
        @(posedge core_clk) disable iff (sys_rst)
        tok_any |-> tok_won;
    endproperty
    a_token_first: assert property (p_token_first)
        else $error("A master without tokens beat one with tokens.");

endmodule // shb_prio_pick

`default_nettype wire

// >>> core/shb_reg_window.sv
/*
 * Chip register region: one-word write buffer, read stall, write-before-read.
 * Assumes the register side holds rg_done high for one cycle per command.
 */
`default_nettype none

module shb_reg_window #(
    // Pages of the two fast switch-core targets; values are arbitrary.
    parameter logic [15:0] FAST_ORIGIN_PAGE = 16'h7100,
    parameter logic [15:0] FAST_QUEUE_PAGE = 16'h7101
) (
    // Clock and reset.
    input wire logic core_clk,
    input wire logic sys_rst,
    // Beat from the fabric.
    input wire logic acc_valid,
    input wire logic acc_we,
    input wire logic [31:0] acc_addr,
    input wire logic [31:0] acc_wdata,
    output logic acc_ready,
    output logic [31:0] acc_rdata,
    // Register command port.
    output logic rg_req,
    output logic rg_we,
    output logic [27:0] rg_addr,
    output logic [31:0] rg_wdata,
    output logic rg_remote,
    output logic rg_fast,
    input wire logic rg_done,
    input wire logic [31:0] rg_rdata
);

    shb_pkg::shb_rw_state_t state_r, state_nxt;
    logic [31:0] rdata_r;

    // Writes are taken at once into the buffer; reads wait for an empty buffer.
    wire logic idle = (state_r == shb_pkg::RW_IDLE);
    wire logic take_wr = idle && acc_valid && acc_we;
    wire logic take_rd = idle && acc_valid && !acc_we;
    wire logic give_rd = (state_r == shb_pkg::RW_RDATA) && acc_valid && !acc_we;
    assign acc_ready = take_wr || give_rd;
    assign acc_rdata = rdata_r;
    assign rg_req = (state_r == shb_pkg::RW_WRITE) || (state_r == shb_pkg::RW_READ);

    // Next state.
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            shb_pkg::RW_IDLE: begin
                if (take_wr) state_nxt = shb_pkg::RW_WRITE;
                else if (take_rd) state_nxt = shb_pkg::RW_READ;
            end
            shb_pkg::RW_WRITE: if (rg_done) state_nxt = shb_pkg::RW_IDLE;
            shb_pkg::RW_READ: if (rg_done) state_nxt = shb_pkg::RW_RDATA;
            shb_pkg::RW_RDATA: if (give_rd) state_nxt = shb_pkg::RW_IDLE;
        endcase
    end

    // State and the command latched at launch.
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            state_r <= shb_pkg::RW_IDLE;
            rg_we <= 1'b0;
            rg_addr <= 28'h0;
            rg_wdata <= 32'h0;
            rg_remote <= 1'b0;
            rg_fast <= 1'b0;
            rdata_r <= 32'h0;
        end else begin
            state_r <= state_nxt;
            if (take_wr || take_rd) begin
                rg_we <= acc_we;
                rg_addr <= acc_addr[shb_pkg::CHIP_OFS_W-1:0];
                rg_wdata <= acc_wdata;
                rg_remote <= (acc_addr >= shb_pkg::BASE_SWC);
                rg_fast <= (acc_addr[31:16] == FAST_ORIGIN_PAGE) ||
                           (acc_addr[31:16] == FAST_QUEUE_PAGE);
            end
            if (state_r == shb_pkg::RW_READ && rg_done) rdata_r <= rg_rdata;
        end
    end

    property p_write_stall;
        @(posedge core_clk) disable iff (sys_rst)
        (state_r == shb_pkg::RW_WRITE) && acc_valid && acc_we |-> !acc_ready;
    endproperty
    a_write_stall: assert property (p_write_stall)
        else $error("Second write passed a full write buffer.");

    property p_read_after_write;
        @(posedge core_clk) disable iff (sys_rst)
        (state_r == shb_pkg::RW_WRITE) && acc_valid && !acc_we |-> !rg_req || rg_we;
    endproperty
    a_read_after_write: assert property (p_read_after_write)
        else $error("Read launched while a buffered write was pending.");

endmodule // shb_reg_window

`default_nettype wire

// >>> core/shb_bus_fabric.sv
/*
 * Shared bus fabric: address decode, three-master arbitration with optional
 * weighted tokens, and routing of beats to flash, memory, register and PCIe ports.
 * Assumes a master holds its beat until ready and marks the last beat of a burst.
 */
`default_nettype none

// Function
// - Boot 512MB: flash mirror low, then reserved.
// - Normal 512MB: lowest 512MB mirrors memory.
// - Fixed regions decoded in both modes.
// - Large memory: 1GB at 0x80000000, wider mirrors.
// - CPU-only soft reset keeps the mapping.
// - Frame DMA memory path stays separate.
// - Strict priority, per-master levels, CPU default.
// - Level 15 is the highest priority.
// - Token mode guarantees bandwidth, shares unused.
// - Tokens reload with weights each period.
// - Tokens drop one per occupied cycle.
// - Masters with tokens beat masters without.
// - Levels order each token group.
// - Weight zero means unlimited tokens.
// - Register region takes 32-bit accesses only.
// - One-word write buffer; next write stalls.
// - Register reads stall until data returns.
// - Buffered write finishes before a read.
// - Local registers served in few cycles.
// - Switch-core range forwarded, fast targets flagged.
// - Flash reads go out; flash writes refused.
// - Memory region maps to memory controller.
// - Boot mode after every subsystem reset.
// - New mapping applied at control readback.
module shb_bus_fabric (
    // Clock and reset.
    input wire logic core_clk,
    input wire logic sys_rst,
    // Master beats, indexed CPU, PCIe, register-bus access block.
    input wire logic [2:0] m_req,
    input wire logic [2:0] m_we,
    input wire logic [2:0] m_last,
    input wire logic [2:0][1:0] m_size,
    input wire logic [2:0][31:0] m_addr,
    input wire logic [2:0][31:0] m_wdata,
    output logic [2:0] m_grant,
    output logic [2:0] m_ready,
    output logic [2:0] m_rvalid,
    output logic m_rerr,
    output logic [31:0] m_rdata,
    // Arbitration settings.
    input wire logic [3:0] cpu_priority_level,
    input wire logic [3:0] pcie_priority_level,
    input wire logic [3:0] regbus_access_priority_level,
    input wire logic token_mode_enable,
    input wire logic [15:0] token_refresh_period,
    input wire logic [15:0] cpu_token_weight,
    input wire logic [15:0] pcie_token_weight,
    input wire logic [15:0] regbus_access_token_weight,
    // Map control and soft reset.
    input wire logic large_memory_enable,
    input wire logic boot_map_select,
    input wire logic map_select_read,
    input wire logic cpu_soft_rst,
    input wire logic cpu_rst_only,
    output logic boot_mode,
    // Flash read port.
    output logic fl_valid,
    output logic [27:0] fl_addr,
    input wire logic fl_ready,
    input wire logic [31:0] fl_rdata,
    // Memory controller port.
    output logic ddr_valid,
    output logic ddr_we,
    output logic [1:0] ddr_size,
    output logic [29:0] ddr_addr,
    output logic [31:0] ddr_wdata,
    input wire logic ddr_ready,
    input wire logic [31:0] ddr_rdata,
    // PCIe outbound port.
    output logic pcie_valid,
    output logic pcie_we,
    output logic [1:0] pcie_size,
    output logic [29:0] pcie_addr,
    output logic [31:0] pcie_wdata,
    input wire logic pcie_ready,
    input wire logic [31:0] pcie_rdata,
    // Register command port.
    output logic rg_req,
    output logic rg_we,
    output logic [27:0] rg_addr,
    output logic [31:0] rg_wdata,
    output logic rg_remote,
    output logic rg_fast,
    input wire logic rg_done,
    input wire logic [31:0] rg_rdata
);

    logic boot_r;
    logic busy_r;
    logic [2:0] owner_r;
    logic [2:0][15:0] tok_r;
    logic [15:0] per_r;
    logic [2:0] rsp_r;
    logic rerr_r;
    logic [31:0] rdata_r;

    // Mapping: subsystem reset or a full soft reset returns to boot mode, while a
    // soft reset restricted to the CPU leaves the map as it was.
    wire logic sys_soft = cpu_soft_rst && !cpu_rst_only;
    always_ff @(posedge core_clk) begin
        if (sys_rst) boot_r <= 1'b1;
        else if (sys_soft) boot_r <= 1'b1;
        else if (map_select_read) boot_r <= boot_map_select;
    end
    assign boot_mode = boot_r;

    // Per-master settings gathered by index.
    wire logic [2:0][3:0] level = {regbus_access_priority_level, pcie_priority_level,
                                   cpu_priority_level};
    wire logic [2:0][15:0] weight = {regbus_access_token_weight, pcie_token_weight,
                                     cpu_token_weight};

    // Token state per master; zero weight never runs dry.
    logic [2:0] has_tok;
    logic [2:0][4:0] key;
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            has_tok[i] = (weight[i] == 16'h0) || (tok_r[i] != 16'h0);
            key[i] = {token_mode_enable && has_tok[i], level[i]};
        end
    end

    // Picks a new owner only while the bus is free.
    logic [2:0] pick;
    shb_prio_pick u_pick (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .req(m_req),
        .key(key),
        .pick(pick)
    );

    // Beat of the current owner.
    logic [1:0] own_idx;
    always_comb begin
        own_idx = 2'h0;
        for (int i = 0; i < 3; i++) begin
            if (owner_r[i]) own_idx = 2'(i);
        end
    end
    wire logic b_req = busy_r && m_req[own_idx];
    wire logic b_we = m_we[own_idx];
    wire logic [1:0] b_size = m_size[own_idx];
    wire logic [31:0] b_addr = m_addr[own_idx];
    wire logic [31:0] b_wdata = m_wdata[own_idx];
    wire shb_pkg::shb_region_t region =
        shb_pkg::decode_region(b_addr, boot_r, large_memory_enable);

    // Refused beats: reserved space, flash writes, narrow or out-of-range register access.
    wire logic is_flash = (region == shb_pkg::RG_FLASH) || (region == shb_pkg::RG_FLASH_MIR);
    wire logic is_ddr = (region == shb_pkg::RG_DDR) || (region == shb_pkg::RG_DDR_MIR);
    wire logic is_chip = (region == shb_pkg::RG_CHIP);
    wire logic is_pcie = (region == shb_pkg::RG_PCIE);
    wire logic chip_ok = (b_size == shb_pkg::SZ_WORD) && (b_addr < shb_pkg::END_SWC);
    wire logic b_err = (region == shb_pkg::RG_RSVD) || (is_flash && b_we) ||
                       (is_chip && !chip_ok);

    // Target strobes. The memory port carries shared bus traffic only; the frame
    // DMA reaches memory and PCIe on its own path, so register stalls here never
    // throttle it.
    assign fl_valid = b_req && is_flash && !b_we;
    assign fl_addr = b_addr[shb_pkg::FLASH_OFS_W-1:0];
    assign ddr_valid = b_req && is_ddr;
    assign ddr_we = b_we;
    assign ddr_size = b_size;
    assign ddr_addr = (region == shb_pkg::RG_DDR && !large_memory_enable) ?
                      {1'b0, b_addr[28:0]} : b_addr[shb_pkg::DDR_OFS_W-1:0];
    assign ddr_wdata = b_wdata;
    assign pcie_valid = b_req && is_pcie;
    assign pcie_we = b_we;
    assign pcie_size = b_size;
    assign pcie_addr = b_addr[shb_pkg::DDR_OFS_W-1:0];
    assign pcie_wdata = b_wdata;

    // Register region window; it stalls the beat as the buffer and reads require.
    wire logic rw_valid = b_req && is_chip && chip_ok;
    logic rw_ready;
    logic [31:0] rw_rdata;
    shb_reg_window u_regwin (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .acc_valid(rw_valid),
        .acc_we(b_we),
        .acc_addr(b_addr),
        .acc_wdata(b_wdata),
        .acc_ready(rw_ready),
        .acc_rdata(rw_rdata),
        .rg_req(rg_req),
        .rg_we(rg_we),
        .rg_addr(rg_addr),
        .rg_wdata(rg_wdata),
        .rg_remote(rg_remote),
        .rg_fast(rg_fast),
        .rg_done(rg_done),
        .rg_rdata(rg_rdata)
    );

    // Beat completion and read data selection.
    wire logic tgt_ready = b_err ? 1'b1 : is_flash ? fl_ready : is_ddr ? ddr_ready :
                           is_pcie ? pcie_ready : rw_ready;
    wire logic [31:0] tgt_rdata = is_flash ? fl_rdata : is_ddr ? ddr_rdata :
                                  is_pcie ? pcie_rdata : rw_rdata;
    wire logic accept = b_req && tgt_ready;
    wire logic burst_end = accept && m_last[own_idx];
    assign m_ready = owner_r & {3{accept}};
    assign m_grant = owner_r;

    // Ownership lasts from the pick to the accepted last beat, so a burst is never split.
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            busy_r <= 1'b0;
            owner_r <= 3'h0;
        end else if (!busy_r) begin
            busy_r <= |pick;
            owner_r <= pick;
        end else if (burst_end) begin
            busy_r <= 1'b0;
            owner_r <= 3'h0;
        end
    end

    // Refresh period counter; tokens reload when it wraps or while the mode is off.
    // A period of zero wraps to 16'hffff, so tokens reload only every 65536 cycles.
    wire logic refresh = !token_mode_enable || (per_r == 16'h0);
    always_ff @(posedge core_clk) begin
        if (sys_rst) per_r <= 16'h0;
        else if (refresh) per_r <= token_refresh_period - 16'h1;
        else per_r <= per_r - 16'h1;
    end

    // Tokens: the owner pays one per cycle of occupancy; an empty count drops the
    // master into the low group, and unused guarantee falls to whoever requests.
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            tok_r <= '0;
        end else begin
            for (int i = 0; i < 3; i++) begin
                if (refresh) tok_r[i] <= weight[i];
                else if (busy_r && owner_r[i] && tok_r[i] != 16'h0)
                    tok_r[i] <= tok_r[i] - 16'h1;
            end
        end
    end

    // Answer to the owner one cycle after its beat is accepted.
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            rsp_r <= 3'h0;
            rerr_r <= 1'b0;
            rdata_r <= 32'h0;
        end else begin
            rsp_r <= m_ready;
            if (accept) begin
                rerr_r <= b_err;
                rdata_r <= (b_err || b_we) ? 32'h0 : tgt_rdata;
            end
        end
    end
    assign m_rvalid = rsp_r;
    assign m_rerr = rerr_r;
    assign m_rdata = rdata_r;

    // Ownership: one master at a time, held until its burst ends.
    property p_one_owner;
        @(posedge core_clk) disable iff (sys_rst)
        $onehot0(owner_r) && (busy_r == (owner_r != 3'h0));
    endproperty
    a_one_owner: assert property (p_one_owner)
        else $error("Bus owner is not a single master.");

    property p_hold_owner;
        @(posedge core_clk) disable iff (sys_rst)
        busy_r && !burst_end |=> owner_r == $past(owner_r);
    endproperty
    a_hold_owner: assert property (p_hold_owner)
        else $error("Owner changed in the middle of a burst.");

    // Mapping: boot after reset, readback applies, a CPU-only reset keeps it.
    property p_boot_after_reset;
        @(posedge core_clk)
        sys_rst |=> boot_r;
    endproperty
    a_boot_after_reset: assert property (p_boot_after_reset)
        else $error("Boot mode not entered after reset.");

    property p_map_at_read;
        @(posedge core_clk) disable iff (sys_rst)
        map_select_read && !sys_soft |=> boot_r == $past(boot_map_select);
    endproperty
    a_map_at_read: assert property (p_map_at_read)
        else $error("Mapping did not follow the readback.");

    property p_cpu_only_keeps;
        @(posedge core_clk) disable iff (sys_rst)
        cpu_soft_rst && cpu_rst_only && !map_select_read |=> $stable(boot_r);
    endproperty
    a_cpu_only_keeps: assert property (p_cpu_only_keeps)
        else $error("CPU-only soft reset changed the mapping.");

    // Refused beats answer with an error and strobe no target.
    property p_flash_write_refused;
        @(posedge core_clk) disable iff (sys_rst)
        b_req && is_flash && b_we |-> !fl_valid ##1 m_rerr && (m_rvalid != 3'h0);
    endproperty
    a_flash_write_refused: assert property (p_flash_write_refused)
        else $error("Flash write was not refused.");

    // Token bookkeeping follows occupancy and the refresh period; narrow register beats are refused.
    property p_token_spend;
        @(posedge core_clk) disable iff (sys_rst)
        !refresh && busy_r && owner_r[1] && tok_r[1] != 16'h0 |=>
            tok_r[1] == $past(tok_r[1]) - 16'h1;
    endproperty
    a_token_spend: assert property (p_token_spend)
        else $error("PCIe token count not decremented while owning the bus.");

    property p_token_reload;
        @(posedge core_clk) disable iff (sys_rst)
        token_mode_enable && per_r == 16'h0 |=> tok_r[1] == $past(pcie_token_weight);
    endproperty
    a_token_reload: assert property (p_token_reload)
        else $error("PCIe tokens not reloaded at period start.");

    property p_narrow_reg_refused;
        @(posedge core_clk) disable iff (sys_rst)
        b_req && is_chip && b_size != shb_pkg::SZ_WORD |-> !rw_valid ##1 m_rerr;
    endproperty
    a_narrow_reg_refused: assert property (p_narrow_reg_refused)
        else $error("Narrow register access was not refused.");

endmodule // shb_bus_fabric

`default_nettype wire

// >>> bench/shb_tgt_model.sv
/*
 * Far-side responders: flash, memory, PCIe and register targets.
 * Assumes the fabric holds each request steady until it is answered.
 */
`default_nettype none
module shb_tgt_model (
    // Clock.
    input wire logic core_clk,
    // Requests.
    input wire logic fl_valid,
    input wire logic [27:0] fl_addr,
    input wire logic ddr_valid,
    input wire logic pcie_valid,
    input wire logic rg_req,
    input wire logic [27:0] rg_addr,
    // Answers.
    output logic fl_ready,
    output logic [31:0] fl_rdata,
    output logic ddr_ready,
    output logic [31:0] ddr_rdata,
    output logic pcie_ready,
    output logic [31:0] pcie_rdata,
    output logic rg_done,
    output var logic [31:0] rg_rdata
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] cnt = 8'h00;
    logic [1:0] dly = 2'h0;
    // Slow answers alternate with prompt ones; idle data changes each cycle.
    always @(posedge core_clk) begin
        cnt <= cnt + 8'h01;
        dly <= rg_req ? dly + 2'h1 : 2'h0;
    end
    assign fl_ready = fl_valid & cnt[0];
    assign ddr_ready = ddr_valid & cnt[0];
    assign pcie_ready = pcie_valid;
    assign rg_done = rg_req & (dly == 2'h3);
    // Flash and register read data carry the offset, so a wrong or stale word shows.
    assign fl_rdata = fl_ready ? {4'h0, fl_addr} : {4{cnt}};
    assign rg_rdata = rg_done ? {4'h0, rg_addr} : {4{cnt}};
    assign ddr_rdata = {4{cnt}};
    assign pcie_rdata = ~{4{cnt}};
endmodule // shb_tgt_model
`default_nettype wire

// >>> bench/testbench.sv
/*
 * Self-checking bench for the shared bus fabric.
 * Assumes the target model answers every request.
 */
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    logic core_clk, sys_rst, m_rerr, token_mode_enable, large_memory_enable, boot_map_select;
    logic map_select_read, cpu_soft_rst, cpu_rst_only, boot_mode, fl_valid, fl_ready;
    logic ddr_valid, ddr_we, ddr_ready, pcie_valid, pcie_we, pcie_ready, rg_req, rg_we;
    logic rg_remote, rg_fast, rg_done, err;
    logic [2:0] m_req, m_we, m_last, m_grant, m_ready, m_rvalid, r, w;
    logic [2:0][1:0] m_size;
    logic [2:0][31:0] m_addr, m_wdata;
    logic [31:0] m_rdata, fl_rdata, ddr_rdata, ddr_wdata, pcie_rdata, pcie_wdata, rg_wdata;
    logic [31:0] rg_rdata, a, d;
    logic [3:0] cpu_priority_level, pcie_priority_level, regbus_access_priority_level, hit, e;
    logic [15:0] token_refresh_period, cpu_token_weight, pcie_token_weight;
    logic [15:0] regbus_access_token_weight;
    logic [27:0] fl_addr, rg_addr;
    logic [29:0] ddr_addr, pcie_addr;
    logic [1:0] ddr_size, pcie_size;
    int failures, n_tests, seed, cyc;
    logic [31:0] tbl [6] = '{32'h0fff_fffc, 32'h1000_0000, 32'h3ffffffc, 32'h7100_0200,
        32'h7200_0000, 32'hbffffffc};
    shb_bus_fabric shb_bus_fabric_inst (.*);
    shb_tgt_model shb_tgt_model_inst (.*);
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end
    // Targets strobed during the current access.
    always @(posedge core_clk) hit <= hit | {pcie_valid, rg_req, ddr_valid, fl_valid};
    // A hang is cut short here.
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 30000) begin
            failures++;
            final_report();
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic final_report();
        $display("failures %0d comparisons %0d", failures, n_tests);
        if (failures == 0 && n_tests > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // Target one-hot {pcie, chip, memory, flash}; zero means refused.
    function automatic logic [3:0] exp_tgt(input logic [31:0] x, input logic b, input logic g);
        if (x >= 32'hc000_0000) return 4'h8;
        if (x >= 32'h8000_0000) return g ? 4'h2 : 4'h0;
        if (x >= 32'h7200_0000) return 4'h0;
        if (x >= 32'h7000_0000) return 4'h4;
        if (x >= 32'h5000_0000) return 4'h0;
        if (x >= 32'h4000_0000) return 4'h1;
        if (x >= 32'h2000_0000 && !g) return 4'h2;
        if (!b) return 4'h2;
        return (x < 32'h1000_0000) ? 4'h1 : 4'h0;
    endfunction
    // One beat; a spare cycle at the end lets late strobes land in hit.
    task automatic acc(input int m, input logic we, input logic [1:0] sz, input logic [31:0] x);
        hit = 4'h0;
        @(posedge core_clk);
        m_req[m] <= 1'b1;
        m_we[m] <= we;
        m_size[m] <= sz;
        m_addr[m] <= x;
        do @(negedge core_clk); while (m_ready[m] !== 1'b1);
        @(posedge core_clk);
        m_req[m] <= 1'b0;
        @(negedge core_clk);
        check(m_rvalid[m], 1);
        err = m_rerr;
        d = m_rdata;
        @(negedge core_clk);
    endtask
    // Levels and all three requests go out on one edge; the first grant is compared.
    task automatic race(input logic [11:0] lv, input logic [2:0] exp);
        @(posedge core_clk);
        {cpu_priority_level, pcie_priority_level, regbus_access_priority_level} <= lv;
        m_req <= 3'h7;
        do @(negedge core_clk); while (m_grant === 3'h0);
        check(m_grant, exp);
        do begin
            r = m_ready;
            @(posedge core_clk);
            m_req <= m_req & ~r;
            @(negedge core_clk);
        end while ((m_req & ~r) != 3'h0);
        repeat (2) @(negedge core_clk);
    endtask
    initial begin
        {m_req, m_we, m_size, m_wdata, cyc, failures, n_tests, hit} = '0;
        {cpu_priority_level, pcie_priority_level, regbus_access_priority_level} = '0;
        {token_mode_enable, cpu_token_weight, pcie_token_weight, cpu_soft_rst, cpu_rst_only} = '0;
        {regbus_access_token_weight, large_memory_enable, map_select_read} = '0;
        m_last = 3'h7;
        m_addr = {3{32'h8000_0000}};
        token_refresh_period = 16'h0100;
        boot_map_select = 1'b1;
        seed = 32'h3b8e;
        sys_rst = 1'b1;
        repeat (4) @(posedge core_clk);
        sys_rst <= 1'b0;
        @(negedge core_clk);
        check(boot_mode, 1);
        for (int md = 0; md < 4; md++) begin
            @(posedge core_clk);
            boot_map_select <= !md[0];
            large_memory_enable <= md[1];
            map_select_read <= 1'b1;
            @(posedge core_clk);
            map_select_read <= 1'b0;
            @(negedge core_clk);
            check(boot_mode, !md[0]);
            for (int i = 0; i < 14; i++) begin
                a = (i < 6) ? tbl[i] : ($random(seed) & 32'hffff_fffc);
                e = exp_tgt(a, !md[0], md[1]);
                acc(0, 1'b0, shb_pkg::SZ_WORD, a);
                check(err, e == 4'h0);
                check(hit, e);
                if (e[2] || e[0]) check(d, {4'h0, a[27:0]});
            end
            acc(1, 1'b1, shb_pkg::SZ_WORD, 32'h4000_0010);
            check({err, hit}, 5'h10);
            acc(1, 1'b0, 2'h1, 32'h7000_0010);
            check({err, hit}, 5'h10);
        end
        for (int k = 1; k >= 0; k--) begin
            @(posedge core_clk);
            cpu_rst_only <= k[0];
            cpu_soft_rst <= 1'b1;
            @(posedge core_clk);
            cpu_soft_rst <= 1'b0;
            @(negedge core_clk);
            check(boot_mode, !k[0]);
        end
        for (int i = 0; i < 10; i++) begin
            a = $random(seed);
            w = (a[7:4] > a[11:8]) ? 3'h2 : 3'h1;
            if (a[3:0] > (w[1] ? a[7:4] : a[11:8])) w = 3'h4;
            race(a[11:0], w);
        end
        @(posedge core_clk);
        pcie_token_weight <= 16'h0001;
        @(posedge core_clk);
        token_mode_enable <= 1'b1;
        race(12'h0f0, 3'h2);
        race(12'h0f0, 3'h1);
        repeat (300) @(posedge core_clk);
        race(12'h0f0, 3'h2);
        acc(2, 1'b1, shb_pkg::SZ_WORD, 32'h7000_0100);
        acc(2, 1'b1, shb_pkg::SZ_WORD, 32'h7000_0104);
        acc(2, 1'b0, shb_pkg::SZ_WORD, 32'h7000_0108);
        check(d, 32'h0000_0108);
        final_report();
    end
endmodule // testbench
`default_nettype wire
